// ==== src/fsp_protect_top.sv ====
// sector guard controller: protection status, lock config word, mode entry
`timescale 1ns/1ps

// Summary of operation
// - nonvolatile zero protects; else volatile bit decides
// - lock word bits: secure, persistent, password, erase-option
// - bit 0 zero locks the secured area
// - password bit one, persistent zero: persistent mode
// - password mode needs bit 1 one; bit 3 factory
// - bit 3 reads global erase enable
// - bit 4 factory, power-up volatile state
// - bits 15 to 5 read as ones
// - lock mode blocks bank 0 array access
// - programming both mode bits zero aborts
// - one mode bit programmed forbids the other
// - no mode entry while suspended
// - lock programming: poll bank 0, refuse others
// - program bits singly, erase all together
// - nonvolatile programming refuses other-bank reads
// - guard mode: bank reads return guard bit
// - freeze bit set: guard program/erase times out unchanged; lock programming still completes
// - exit returns read mode, unblocks bank
// - operation on protected sector ignored, read mode
// - freeze bit cleared only by reset
// - volatile bits reset to VOL_PWRUP, unprotected at the default of one
module fsp_protect_top import fsp_pkg::*; #(
  parameter logic OTP_ERASE_EN = 1'b1,  // factory option, arbitrary default
  parameter logic VOL_PWRUP    = 1'b1   // factory power-up volatile state
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // command from the host controller
  input  wire logic              i_cmd_valid,
  input  wire fsp_cmd_e          i_cmd_op,
  input  wire logic [SEC_W-1:0]  i_cmd_sector,
  input  wire logic [DATA_W-1:0] i_cmd_data,
  input  wire logic              i_suspended,
  // read request
  input  wire logic              i_rd_req,
  input  wire logic [SEC_W-1:0]  i_rd_sector,
  // read answer
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_rd_refused,
  output logic                   o_rd_array,
  // command results
  output logic                   o_busy,
  output logic                   o_op_done,
  output logic                   o_op_abort,
  output logic                   o_op_timeout,
  output logic                   o_cmd_refused,
  output logic                   o_array_go,
  output logic                   o_array_ignored,
  // state
  output fsp_mode_e              o_mode,
  output logic                   o_bank_blocked,
  output logic [BANK_W-1:0]      o_blocked_bank,
  output logic                   o_secure_locked,
  output logic                   o_persistent_mode,
  output logic                   o_password_mode,
  output logic                   o_freeze
);

  // --------------------
  // state
  // --------------------
  fsp_mode_e          mode_r, mode_nxt;
  fsp_op_e            op_r;
  fsp_rdk_e           rd_kind_r, rd_kind_nxt;
  logic [LR_NV_W-1:0] lock_r;
  logic               freeze_r;
  logic [NUM_SEC-1:0] vol_r;
  logic [BANK_W-1:0]  ent_bank_r;
  logic [SEC_W-1:0]   pend_sec_r;
  logic [LR_NV_W-1:0] pend_data_r;
  logic               frz_hit_r;
  logic               rd_p_r;
  logic [SEC_W-1:0]   rd_sec_r;
  logic [DATA_W-1:0]  rd_word_r;
  logic               ac_p_r;
  logic [SEC_W-1:0]   ac_sec_r;
  logic               tmr_busy;
  logic               tmr_done;
  // output registers
  logic              rd_valid_r, rd_refused_r, rd_array_r;
  logic [DATA_W-1:0] rd_data_r;
  logic              done_r, abort_r, tout_r, refused_r, go_r, ign_r;
  logic              blk_r, sec_lk_r, pers_r, pass_r;

  fsp_mem_if mif ();

  // --------------------
  // command decode
  // --------------------
  wire cmd_v      = i_cmd_valid && (i_cmd_op != CMD_NOP);
  wire busy       = tmr_busy;
  wire is_entry   = i_cmd_op inside {CMD_ENTER_LOCK, CMD_ENTER_NV, CMD_ENTER_VOL};
  wire entry_ok   = cmd_v && is_entry && (mode_r == MD_READ) && !i_suspended &&
                    !busy;
  wire exit_ok    = cmd_v && (i_cmd_op == CMD_EXIT) && !busy;
  wire lock_cmd   = cmd_v && (i_cmd_op == CMD_LOCK_PROG) && (mode_r == MD_LOCK) && !busy;
  wire d_pers     = i_cmd_data[LR_PERSIST];
  wire d_pass     = i_cmd_data[LR_PASSWD];
  wire both_zero  = !d_pers && !d_pass;
  wire scheme_bad = (!lock_r[LR_PASSWD] && !d_pers) ||
                    (!lock_r[LR_PERSIST] && !d_pass);
  wire lock_bad   = both_zero || scheme_bad;
  wire lock_go    = lock_cmd && !lock_bad;
  wire lock_abort = lock_cmd && lock_bad;
  wire nv_prog    = cmd_v && (i_cmd_op == CMD_NV_PROG) && (mode_r == MD_NV) && !busy;
  wire nv_erase   = cmd_v && (i_cmd_op == CMD_NV_ERASE) && (mode_r == MD_NV) && !busy;
  wire vol_cmd    = cmd_v && (i_cmd_op inside {CMD_VOL_SET, CMD_VOL_CLR}) &&
                    (mode_r == MD_VOL) && !busy;
  wire frz_cmd    = cmd_v && (i_cmd_op == CMD_FREEZE_SET) && !busy;
  wire cmd_bank_blk = (mode_r != MD_READ) && (sector_bank(i_cmd_sector) == ent_bank_r);
  wire arr_cmd    = cmd_v && (i_cmd_op inside {CMD_ARR_PROG, CMD_ARR_ERASE}) &&
                    !busy && !ac_p_r && !cmd_bank_blk;
  wire accepted   = entry_ok || exit_ok || lock_cmd || nv_prog || nv_erase ||
                    vol_cmd || frz_cmd || arr_cmd;

  // operation timing select
  wire                   tmr_start  = lock_go || nv_prog || nv_erase;
  wire [TMR_W-1:0]       tmr_cycles = lock_go ? LOCK_PROG_CYC :
                                      nv_prog ? NV_PROG_CYC : NV_ERASE_CYC;
  wire                   commit     = tmr_done && !frz_hit_r;
  // array command protection check, one cycle after the store read
  wire ac_prot = is_protected(mif.rdata_b, vol_r[ac_sec_r]);
  wire ac_ign  = ac_p_r && ac_prot;

  // --------------------
  // store connections; single bits programmed, erase is global
  // --------------------
  assign mif.we        = commit && (op_r == OP_NV_PROG);
  assign mif.erase_all = commit && (op_r == OP_NV_ERASE);
  assign mif.wdata     = 1'b0;
  assign mif.waddr     = pend_sec_r;
  assign mif.raddr_a   = i_rd_sector;
  assign mif.raddr_b   = i_cmd_sector;

  // --------------------
  // lock config word as software reads it
  // --------------------
  wire [DATA_W-1:0] lr_word = LR_RSVD_ONES |
                              {WORD_ZERO[DATA_W-1:LR_VOL_PUP+1], VOL_PWRUP, OTP_ERASE_EN,
                               lock_r};
  wire [DATA_W-1:0] stat_word = WORD_ZERO | (DATA_W'(busy) << STAT_BUSY);

  // --------------------
  // read routing by mode and running operation
  // --------------------
  wire [BANK_W-1:0] rd_bank  = sector_bank(i_rd_sector);
  wire              lk_busy  = busy && (op_r == OP_LOCK);
  wire              nv_busy  = busy && (op_r != OP_LOCK);
  wire              in_ent   = (rd_bank == ent_bank_r);
  wire              in_bank0 = (rd_bank == BANK_ZERO);

  always_comb begin
    rd_kind_nxt = RK_ARRAY;
    if (lk_busy) begin
      rd_kind_nxt = in_bank0 ? RK_WORD : RK_REFUSE;
    end else if (nv_busy) begin
      rd_kind_nxt = in_ent ? RK_WORD : RK_REFUSE;
    end else if (mode_r == MD_LOCK) begin
      rd_kind_nxt = in_bank0 ? RK_WORD : RK_ARRAY;
    end else if (mode_r == MD_NV) begin
      rd_kind_nxt = in_ent ? RK_NV : RK_ARRAY;
    end else if (mode_r == MD_VOL) begin
      rd_kind_nxt = in_ent ? RK_VOL : RK_ARRAY;
    end
  end

  // --------------------
  // mode sequencing
  // --------------------
  always_comb begin
    mode_nxt = mode_r;
    if (entry_ok) begin
      unique case (i_cmd_op)
        CMD_ENTER_LOCK: mode_nxt = MD_LOCK;
        CMD_ENTER_NV:   mode_nxt = MD_NV;
        default:        mode_nxt = MD_VOL;
      endcase
    end else if (exit_ok) begin
      mode_nxt = MD_READ;
    end else if (ac_ign) begin
      mode_nxt = MD_READ;
    end
  end

  // mode and blocked bank
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r     <= MD_READ;
      ent_bank_r <= BANK_ZERO;
      blk_r      <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      blk_r  <= (mode_nxt != MD_READ);
      if (entry_ok) begin
        ent_bank_r <= (i_cmd_op == CMD_ENTER_LOCK) ? BANK_ZERO : sector_bank(i_cmd_sector);
      end
    end
  end

  // pending embedded operation; freeze is sampled at the start
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      op_r        <= OP_NONE;
      pend_sec_r  <= '0;
      pend_data_r <= LR_NV_RESET;
      frz_hit_r   <= 1'b0;
    end else if (tmr_start) begin
      op_r        <= lock_go ? OP_LOCK : (nv_prog ? OP_NV_PROG : OP_NV_ERASE);
      pend_sec_r  <= i_cmd_sector;
      pend_data_r <= i_cmd_data[LR_NV_W-1:0];
      frz_hit_r   <= !lock_go && !freeze_r;
    end else if (tmr_done) begin
      op_r <= OP_NONE;
    end
  end

  // lock bits only go from one to zero
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lock_r <= LR_NV_RESET;
    end else if (tmr_done && (op_r == OP_LOCK)) begin
      lock_r <= lock_r & pend_data_r;
    end
  end

  // global freeze: set by command, cleared only by reset
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      freeze_r <= 1'b1;
    end else if (frz_cmd) begin
      freeze_r <= 1'b0;
    end
  end

  // volatile guard bits: set is zero, clear is one
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vol_r <= {NUM_SEC{VOL_PWRUP}};
    end else if (vol_cmd) begin
      vol_r[i_cmd_sector] <= (i_cmd_op == CMD_VOL_CLR);
    end
  end

  // read pipeline, stage one: classify and capture
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_p_r    <= 1'b0;
      rd_kind_r <= RK_ARRAY;
      rd_sec_r  <= '0;
      rd_word_r <= WORD_ZERO;
    end else begin
      rd_p_r    <= i_rd_req;
      rd_kind_r <= rd_kind_nxt;
      rd_sec_r  <= i_rd_sector;
      rd_word_r <= (lk_busy || nv_busy) ? stat_word : lr_word;
    end
  end

  // read pipeline, stage two: answer
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_valid_r   <= 1'b0;
      rd_refused_r <= 1'b0;
      rd_array_r   <= 1'b0;
      rd_data_r    <= WORD_ZERO;
    end else begin
      rd_valid_r   <= rd_p_r && (rd_kind_r != RK_REFUSE);
      rd_refused_r <= rd_p_r && (rd_kind_r == RK_REFUSE);
      rd_array_r   <= rd_p_r && (rd_kind_r == RK_ARRAY);
      unique case (rd_kind_r)
        RK_WORD: rd_data_r <= rd_word_r;
        RK_NV:   rd_data_r <= bit_word(mif.rdata_a);
        RK_VOL:  rd_data_r <= bit_word(vol_r[rd_sec_r]);
        default: rd_data_r <= WORD_ZERO;
      endcase
    end
  end

  // array command check
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ac_p_r   <= 1'b0;
      ac_sec_r <= '0;
    end else begin
      ac_p_r   <= arr_cmd;
      ac_sec_r <= i_cmd_sector;
    end
  end

  // result pulses and derived mode flags
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_r    <= 1'b0;
      abort_r   <= 1'b0;
      tout_r    <= 1'b0;
      refused_r <= 1'b0;
      go_r      <= 1'b0;
      ign_r     <= 1'b0;
      sec_lk_r  <= 1'b0;
      pers_r    <= 1'b0;
      pass_r    <= 1'b0;
    end else begin
      done_r    <= commit;
      abort_r   <= lock_abort;
      tout_r    <= tmr_done && frz_hit_r;
      refused_r <= cmd_v && !accepted;
      go_r      <= ac_p_r && !ac_prot;
      ign_r     <= ac_ign;
      sec_lk_r  <= !lock_r[LR_SECURE];
      pers_r    <= lock_r[LR_PASSWD] && !lock_r[LR_PERSIST];
      pass_r    <= !lock_r[LR_PASSWD] && lock_r[LR_PERSIST];
    end
  end

  // --------------------
  // submodules
  // --------------------
  fsp_guard_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .m         (mif.mem)
  );

  fsp_op_timer u_tmr (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (tmr_start),
    .i_cycles  (tmr_cycles),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  // --------------------
  // outputs
  // --------------------
  assign o_rd_valid        = rd_valid_r;
  assign o_rd_data         = rd_data_r;
  assign o_rd_refused      = rd_refused_r;
  assign o_rd_array        = rd_array_r;
  assign o_busy            = tmr_busy;
  assign o_op_done         = done_r;
  assign o_op_abort        = abort_r;
  assign o_op_timeout      = tout_r;
  assign o_cmd_refused     = refused_r;
  assign o_array_go        = go_r;
  assign o_array_ignored   = ign_r;
  assign o_mode            = mode_r;
  assign o_bank_blocked    = blk_r;
  assign o_blocked_bank    = ent_bank_r;
  assign o_secure_locked   = sec_lk_r;
  assign o_persistent_mode = pers_r;
  assign o_password_mode   = pass_r;
  assign o_freeze          = freeze_r;

endmodule

// ==== src/fsp_pkg.sv ====
// shared constants, types and helpers of the sector guard logic
package fsp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int SEC_W   = 6;
  localparam int SUB_W   = 2;
  localparam int BANK_W  = 4;
  localparam int NUM_SEC = 64;
  localparam int DATA_W  = 16;
  localparam int TMR_W   = 8;

  localparam logic [BANK_W-1:0] BANK_ZERO = 4'h0;

  // ---------------------------------------------------------------
  // protection mode lock config word layout
  // ---------------------------------------------------------------
  localparam int LR_SECURE  = 0;
  localparam int LR_PERSIST = 1;
  localparam int LR_PASSWD  = 2;
  localparam int LR_OTP_ERA = 3;
  localparam int LR_VOL_PUP = 4;
  localparam int LR_NV_W    = 3;

  localparam logic [DATA_W-1:0] LR_RSVD_ONES = 16'hffe0;
  localparam logic [LR_NV_W-1:0] LR_NV_RESET = 3'h7;
  localparam logic [DATA_W-1:0] WORD_ZERO    = 16'h0000;
  localparam int STAT_BUSY = 0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOCK_PROG_NS  = 1000;
  localparam int NV_PROG_NS    = 1000;
  localparam int NV_ERASE_NS   = 2000;
  localparam logic [TMR_W-1:0] LOCK_PROG_CYC =
    TMR_W'((LOCK_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] NV_PROG_CYC =
    TMR_W'((NV_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] NV_ERASE_CYC =
    TMR_W'((NV_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_ENTER_LOCK = 4'h1,
    CMD_ENTER_NV   = 4'h2,
    CMD_ENTER_VOL  = 4'h3,
    CMD_EXIT       = 4'h4,
    CMD_LOCK_PROG  = 4'h5,
    CMD_NV_PROG    = 4'h6,
    CMD_NV_ERASE   = 4'h7,
    CMD_VOL_SET    = 4'h8,
    CMD_VOL_CLR    = 4'h9,
    CMD_FREEZE_SET = 4'ha,
    CMD_ARR_PROG   = 4'hb,
    CMD_ARR_ERASE  = 4'hc
  } fsp_cmd_e;

  typedef enum logic [1:0] {
    MD_READ = 2'h0,
    MD_LOCK = 2'h1,
    MD_NV   = 2'h2,
    MD_VOL  = 2'h3
  } fsp_mode_e;

  typedef enum logic [1:0] {
    OP_NONE     = 2'h0,
    OP_LOCK     = 2'h1,
    OP_NV_PROG  = 2'h2,
    OP_NV_ERASE = 2'h3
  } fsp_op_e;

  typedef enum logic [2:0] {
    RK_ARRAY  = 3'h0,
    RK_REFUSE = 3'h1,
    RK_WORD   = 3'h2,
    RK_NV     = 3'h3,
    RK_VOL    = 3'h4
  } fsp_rdk_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [BANK_W-1:0] sector_bank(input logic [SEC_W-1:0] s);
    return s[SEC_W-1:SUB_W];
  endfunction

  // a zero in either bit protects; both must be one to unprotect
  function automatic logic is_protected(input logic nv, input logic vol);
    return ~(nv & vol);
  endfunction

  function automatic logic [DATA_W-1:0] bit_word(input logic b);
    return {WORD_ZERO[DATA_W-1:1], b};
  endfunction

endpackage

// ==== src/fsp_mem_if.sv ====
// carrier between the controller and the nonvolatile guard bit store
`timescale 1ns/1ps
interface fsp_mem_if import fsp_pkg::*; ();
  logic             we;
  logic             erase_all;
  logic             wdata;
  logic [SEC_W-1:0] waddr;
  logic [SEC_W-1:0] raddr_a;
  logic [SEC_W-1:0] raddr_b;
  logic             rdata_a;
  logic             rdata_b;

  modport ctrl (output we, erase_all, wdata, waddr, raddr_a, raddr_b,
                input  rdata_a, rdata_b);
  modport mem  (input  we, erase_all, wdata, waddr, raddr_a, raddr_b,
                output rdata_a, rdata_b);
endinterface

// ==== src/fsp_guard_mem.sv ====
// per-sector nonvolatile guard bit store with two registered read ports
`timescale 1ns/1ps
module fsp_guard_mem import fsp_pkg::*; (
  // clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_sys_rst,
  // controller side
  fsp_mem_if.mem     m
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [NUM_SEC-1:0] bits_r;
  logic               rd_a_r;
  logic               rd_b_r;

  // reset stands for the shipped, all-erased state
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bits_r <= '1;
    end else if (m.erase_all) begin
      bits_r <= '1;
    end else if (m.we) begin
      bits_r[m.waddr] <= m.wdata;
    end
  end

  // read data always from a register, one cycle after the address
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_a_r <= 1'b1;
      rd_b_r <= 1'b1;
    end else begin
      rd_a_r <= bits_r[m.raddr_a];
      rd_b_r <= bits_r[m.raddr_b];
    end
  end

  assign m.rdata_a = rd_a_r;
  assign m.rdata_b = rd_b_r;

endmodule

// ==== src/fsp_op_timer.sv ====
// down counter that times one embedded program or erase operation
`timescale 1ns/1ps
module fsp_op_timer import fsp_pkg::*; (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // control
  input  wire logic             i_start,
  input  wire logic [TMR_W-1:0] i_cycles,
  // status
  output logic                  o_busy,
  output logic                  o_done
);

  logic [TMR_W-1:0] cnt_r;
  logic             busy_r;
  logic             done_r;

  // start is ignored while running; the controller never overlaps
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && (cnt_r == TMR_ONE);
      if (i_start && !busy_r) begin
        cnt_r  <= i_cycles;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        cnt_r  <= cnt_r - TMR_ONE;
        busy_r <= (cnt_r != TMR_ONE);
      end
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;

endmodule

// ==== verification/fsp_protect_monitor.sv ====
// concurrent checks on the sector guard controller ports
`timescale 1ns/1ps
module fsp_protect_monitor import fsp_pkg::*; (
  // clock and reset
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  // host side
  input wire logic              i_cmd_valid,
  input wire fsp_cmd_e          i_cmd_op,
  input wire logic [DATA_W-1:0] i_cmd_data,
  input wire logic              i_suspended,
  input wire logic              i_rd_req,
  // results and state
  input wire logic              o_rd_valid,
  input wire logic              o_rd_refused,
  input wire logic              o_busy,
  input wire logic              o_op_done,
  input wire logic              o_op_timeout,
  input wire logic              o_op_abort,
  input wire logic              o_cmd_refused,
  input wire fsp_mode_e         o_mode,
  input wire logic              o_bank_blocked,
  input wire logic              o_freeze
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // a command the controller is free to take
  wire take = i_cmd_valid && !o_busy;
  wire lprog = take && i_cmd_op == CMD_LOCK_PROG && o_mode == MD_LOCK;

  AST_RD_ANSWER: assert property (i_rd_req |-> ##2 (o_rd_valid ^ o_rd_refused))
    else $error("read without one answer");
  AST_BOTH_ABORT: assert property (lprog && i_cmd_data[2:1] == 2'h0 |=> o_op_abort)
    else $error("both mode bits not aborted");
  AST_SUSPEND: assert property (take && i_suspended && i_cmd_op == CMD_ENTER_LOCK
    |=> o_cmd_refused) else $error("entry taken while suspended");
  AST_BUSY_REFUSE: assert property (o_busy && i_cmd_valid && i_cmd_op != CMD_NOP
    |=> o_cmd_refused) else $error("command taken while busy");
  AST_EXIT: assert property (take && i_cmd_op == CMD_EXIT |=> o_mode == MD_READ)
    else $error("exit left a mode");
  AST_FREEZE: assert property (!o_freeze |=> !o_freeze)
    else $error("freeze cleared without reset");
  AST_OP_END: assert property ($fell(o_busy) |-> ##[0:1] (o_op_done || o_op_timeout))
    else $error("operation ended without result");
  AST_BLOCK: assert property (o_bank_blocked == (o_mode != MD_READ))
    else $error("bank block out of step with mode");
endmodule

bind fsp_protect_top fsp_protect_monitor u_fsp_protect_monitor (.i_sys_clk, .i_sys_rst,
  .i_cmd_valid, .i_cmd_op, .i_cmd_data, .i_suspended, .i_rd_req, .o_rd_valid, .o_rd_refused,
  .o_busy, .o_op_done, .o_op_timeout, .o_op_abort, .o_cmd_refused, .o_mode, .o_bank_blocked,
  .o_freeze);

// ==== verification/fsp_host_model.sv ====
// host controller model issuing guard commands and reads
`timescale 1ns/1ps
module fsp_host_model import fsp_pkg::*; (
  // clock
  input  wire logic         i_sys_clk,
  // command and read requests
  output logic              o_cmd_valid,
  output fsp_cmd_e          o_cmd_op,
  output logic [SEC_W-1:0]  o_cmd_sector,
  output logic [DATA_W-1:0] o_cmd_data,
  output logic              o_rd_req,
  output logic [SEC_W-1:0]  o_rd_sector
);
  // idle at time zero
  initial begin
    {o_cmd_valid, o_rd_req} = 2'h0;
    o_cmd_op = CMD_NOP;
    {o_cmd_sector, o_cmd_data, o_rd_sector} = '0;
  end
  // one command cycle; data is driven exactly as given
  task automatic cmd(input fsp_cmd_e op, input logic [SEC_W-1:0] s, input logic [DATA_W-1:0] d);
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b1;
    o_cmd_op = op;
    o_cmd_sector = s;
    o_cmd_data = d;
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b0;
    o_cmd_op = CMD_NOP;
    o_cmd_sector = ~s; // stale fields scrambled
    o_cmd_data = ~d;
  endtask
  // single-cycle read request, driven on the falling edge and sampled on the rising edge
  task automatic rd(input logic [SEC_W-1:0] s);
    @(negedge i_sys_clk);
    o_rd_req = 1'b1;
    o_rd_sector = s;
    @(negedge i_sys_clk);
    o_rd_req = 1'b0;
    o_rd_sector = ~s;
  endtask
endmodule

// ==== verification/fsp_protect_top_bench.sv ====
// self-checking bench of the sector guard controller
`timescale 1ns/1ps
module fsp_protect_top_bench import fsp_pkg::*; ;
  logic              i_sys_clk = 1'b0;
  logic              i_sys_rst = 1'b1;
  logic              i_suspended = 1'b0;
  logic              i_cmd_valid, i_rd_req;
  fsp_cmd_e          i_cmd_op;
  logic [SEC_W-1:0]  i_cmd_sector, i_rd_sector;
  logic [DATA_W-1:0] i_cmd_data, o_rd_data;
  logic              o_rd_valid, o_rd_refused, o_rd_array, o_busy, o_op_done, o_op_abort;
  logic              o_op_timeout, o_cmd_refused, o_array_go, o_array_ignored, o_bank_blocked;
  logic              o_secure_locked, o_persistent_mode, o_password_mode, o_freeze;
  fsp_mode_e         o_mode;
  logic [BANK_W-1:0] o_blocked_bank;
  int                fail_count = 0;
  int                tests_run = 0;
  // result pulses, index 5 down to 0: done abort timeout refused go ignored
  wire [5:0] ev = {o_op_done, o_op_abort, o_op_timeout, o_cmd_refused, o_array_go, o_array_ignored};

  fsp_protect_top u_fsp_protect_top (.i_sys_clk, .i_sys_rst, .i_cmd_valid, .i_cmd_op,
    .i_cmd_sector, .i_cmd_data, .i_suspended, .i_rd_req, .i_rd_sector, .o_rd_valid, .o_rd_data,
    .o_rd_refused, .o_rd_array, .o_busy, .o_op_done, .o_op_abort, .o_op_timeout, .o_cmd_refused,
    .o_array_go, .o_array_ignored, .o_mode, .o_bank_blocked, .o_blocked_bank, .o_secure_locked,
    .o_persistent_mode, .o_password_mode, .o_freeze);
  fsp_host_model u_fsp_host_model (.i_sys_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_op(i_cmd_op),
    .o_cmd_sector(i_cmd_sector), .o_cmd_data(i_cmd_data), .o_rd_req(i_rd_req),
    .o_rd_sector(i_rd_sector));

  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // command; returns while the taking edge's pulses stand
  task automatic go(input fsp_cmd_e op, input logic [SEC_W-1:0] s, input logic [DATA_W-1:0] d);
    u_fsp_host_model.cmd(op, s, d);
  endtask
  // bounded wait for one result pulse
  task automatic ev_ok(input string what, input int b, input int n);
    for (int k = 0; k < n && ev[b] !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    check(what, ev[b], 1'b1);
  endtask
  // answer seen at the falling edge after the request drops
  task automatic rdc(input logic [SEC_W-1:0] s, input logic ok, input logic [DATA_W-1:0] exp);
    u_fsp_host_model.rd(s);
    @(negedge i_sys_clk);
    check("rd", {o_rd_valid, o_rd_refused}, {ok, !ok});
    if (ok) check("rd_data", o_rd_data, exp);
  endtask
  task automatic t_lock();
    check("secure", o_secure_locked, 1'b0);
    go(CMD_ARR_PROG, 6'h05, 16'h0000);
    ev_ok("go", 1, 2);
    go(CMD_ENTER_LOCK, 6'h00, 16'h0000);
    rdc(6'h01, 1'b1, 16'hffff);
    rdc(6'h04, 1'b1, 16'h0000);
    check("array", o_rd_array, 1'b1);
    go(CMD_LOCK_PROG, 6'h00, 16'h0006); // reserved bits written as zeros
    go(CMD_EXIT, 6'h00, 16'h0000);
    ev_ok("refused", 2, 1);
    rdc(6'h00, 1'b1, 16'h0001);
    rdc(6'h08, 1'b0, 16'h0000);
    ev_ok("done", 5, 80);
    rdc(6'h00, 1'b1, 16'hfffe);
    check("secure", o_secure_locked, 1'b1);
    go(CMD_LOCK_PROG, 6'h00, 16'hfff9);
    ev_ok("abort", 4, 1);
    go(CMD_LOCK_PROG, 6'h00, 16'hfffd);
    ev_ok("done", 5, 80);
    rdc(6'h00, 1'b1, 16'hfffc);
    go(CMD_LOCK_PROG, 6'h00, 16'hfffb);
    ev_ok("abort", 4, 1);
    check("persist", o_persistent_mode, 1'b1);
    check("passwd", o_password_mode, 1'b0);
    go(CMD_EXIT, 6'h00, 16'h0000);
  endtask
  task automatic t_nv();
    go(CMD_ENTER_NV, 6'h05, 16'h0000);
    check("bank", o_blocked_bank, 4'h1);
    check("blocked", o_bank_blocked, 1'b1);
    rdc(6'h05, 1'b1, 16'h0001);
    go(CMD_NV_PROG, 6'h05, 16'h0000);
    rdc(6'h00, 1'b0, 16'h0000);
    ev_ok("done", 5, 80);
    rdc(6'h05, 1'b1, 16'h0000);
    rdc(6'h06, 1'b1, 16'h0001);
    go(CMD_EXIT, 6'h00, 16'h0000);
    check("mode", o_mode, MD_READ);
    go(CMD_ARR_ERASE, 6'h05, 16'h0000);
    ev_ok("ignored", 0, 2);
    go(CMD_ENTER_NV, 6'h05, 16'h0000);
    go(CMD_NV_ERASE, 6'h00, 16'h0000);
    ev_ok("done", 5, 150);
    rdc(6'h05, 1'b1, 16'h0001);
    go(CMD_EXIT, 6'h00, 16'h0000);
  endtask
  task automatic t_vol_freeze();
    @(negedge i_sys_clk) i_suspended = 1'b1;
    go(CMD_ENTER_LOCK, 6'h08, 16'h0000);
    ev_ok("refused", 2, 1);
    i_suspended = 1'b0;
    go(CMD_ENTER_VOL, 6'h08, 16'h0000);
    go(CMD_VOL_SET, 6'h08, 16'h0000);
    rdc(6'h08, 1'b1, 16'h0000);
    go(CMD_EXIT, 6'h00, 16'h0000);
    go(CMD_ARR_PROG, 6'h08, 16'h0000);
    ev_ok("ignored", 0, 2);
    go(CMD_FREEZE_SET, 6'h00, 16'h0000);
    check("freeze", o_freeze, 1'b0);
    go(CMD_ENTER_NV, 6'h05, 16'h0000);
    go(CMD_NV_PROG, 6'h05, 16'h0000);
    ev_ok("timeout", 3, 80);
    rdc(6'h05, 1'b1, 16'h0001);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    check("freeze", o_freeze, 1'b1);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // reset for 16 cycles, released on a falling edge
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    t_lock();
    t_nv();
    t_vol_freeze();
    complete_run();
  end
  // the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    fail_count++;
    complete_run();
  end
endmodule
